// ===== hw/dps_top.sv
// serial register slave for two 128-tap potentiometers
`timescale 1ns/1ns
module dps_top
    import dps_pkg::*;
#(
    parameter int NV_WRITE_CYCLES = NV_WRITE_CYC
) (
    input  wire logic       mclk_i,
    input  wire logic       rst_n_i,
    input  wire logic       sck_i,
    input  wire logic       cs_n_i,
    input  wire logic       sdi_i,
    input  wire logic       shutdown_control_n_i,
    output logic            sdo_o,
    output logic            sdo_oe_n_o,
    output logic [6:0]      wiper0_tap_o,
    output logic [6:0]      wiper1_tap_o,
    output logic            shutdown_o,
    output logic            standby_o
);

    localparam int WC_W = $clog2(NV_WRITE_CYCLES + 1);

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);

    // ==========================================================
    // pin synchronisers
    dps_pins_t  pin_raw;
    dps_pins_t  s1_r;
    dps_pins_t  s2_r;
    dps_pins_t  s3_r;
    dps_pins_t  pin_r;
    dps_pins_t  prev_r;

    assign pin_raw = '{cs_n: cs_n_i, sck: sck_i, sdi: sdi_i, shutdown_control_n: shutdown_control_n_i};

    for (genvar b = 0; b < 4; b++) begin : g_sync
        always_ff @(posedge mclk_i) begin
            if (!rst_n_i) begin
                s1_r[b]   <= PIN_IDLE[b];
                s2_r[b]   <= PIN_IDLE[b];
                s3_r[b]   <= PIN_IDLE[b];
                pin_r[b]  <= PIN_IDLE[b];
                prev_r[b] <= PIN_IDLE[b];
            end else begin
                s1_r[b]   <= pin_raw[b];
                s2_r[b]   <= s1_r[b];
                s3_r[b]   <= s2_r[b];
                if (s2_r[b] == s3_r[b]) begin
                    pin_r[b] <= s3_r[b];
                end
                prev_r[b] <= pin_r[b];
            end
        end
    end

    logic sck_rise;
    logic sck_fall;
    logic cs_fall;
    logic cs_rise;

    assign sck_rise = pin_r.sck & ~prev_r.sck;
    assign sck_fall = ~pin_r.sck & prev_r.sck;
    assign cs_fall  = ~pin_r.cs_n & prev_r.cs_n;
    assign cs_rise  = pin_r.cs_n & ~prev_r.cs_n;

    // ==========================================================
    // register state
    logic [7:0]       nv_mem_r [NV_CNT] = '{default: NV_ERASED};
    logic [6:0]       wiper_r [2];
    logic             vol_r;
    logic             shutdown_control_bit_r;
    logic             wip_r;
    logic [WC_W-1:0]  wcnt_r;
    logic             pend_r;
    logic [2:0]       pend_addr_r;
    logic [7:0]       pend_data_r;
    logic [7:0]       rcnt_r;
    logic             recall_done_r;

    // ==========================================================
    // serial engine
    dps_state_t  st_r;
    logic [2:0]  bitcnt_r;
    logic [6:0]  sh_r;
    logic [3:0]  ptr_r;
    logic        is_read_r;
    logic [7:0]  rx_byte;
    logic        byte_done;
    logic [3:0]  ptr_next;
    logic        wr_fire;
    logic        wr_ok;
    logic        nv_target;

    assign rx_byte   = {sh_r, pin_r.sdi};
    assign byte_done = sck_rise && (bitcnt_r == 3'h7)
                       && (st_r == ST_ID || st_r == ST_CMD || st_r == ST_DATA);
    assign ptr_next  = (ptr_r >= ADDR_GP_LAST) ? ADDR_POT0 : ptr_r + 4'h1;
    assign wr_fire   = byte_done && (st_r == ST_DATA) && !is_read_r;
    assign wr_ok     = wr_fire && !wip_r;
    assign nv_target = (ptr_r <= ADDR_POT1 && !vol_r)
                       || (ptr_r >= ADDR_GP_FIRST && ptr_r <= ADDR_GP_LAST);

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            st_r      <= ST_IDLE;
            bitcnt_r  <= 3'h0;
            sh_r      <= 7'h00;
            ptr_r     <= ADDR_POT0;
            is_read_r <= 1'b0;
        end else if (pin_r.cs_n) begin
            st_r     <= ST_IDLE;
            bitcnt_r <= 3'h0;
        end else if (cs_fall) begin
            st_r     <= ST_ID;
            bitcnt_r <= 3'h0;
        end else if (sck_rise && st_r != ST_IDLE && st_r != ST_IGNORE) begin
            sh_r     <= rx_byte[6:0];
            bitcnt_r <= bitcnt_r + 3'h1;
            if (byte_done) begin
                case (st_r)
                    ST_ID: begin
                        st_r <= (rx_byte == ID_BYTE) ? ST_CMD : ST_IGNORE;
                    end
                    ST_CMD: begin
                        ptr_r     <= rx_byte[3:0];
                        is_read_r <= (rx_byte[7:4] == OP_READ);
                        if (rx_byte[7:4] == OP_READ || rx_byte[7:4] == OP_WRITE) begin
                            st_r <= ST_DATA;
                        end else begin
                            st_r <= ST_IGNORE;
                        end
                    end
                    ST_DATA: begin
                        ptr_r <= ptr_next;
                    end
                    default: begin
                        st_r <= ST_IGNORE;
                    end
                endcase
            end
        end
    end

    // ==========================================================
    // read path
    logic [3:0]  rd_addr;
    logic [7:0]  rd_val;
    logic        tx_load;
    logic [7:0]  tx_r;

    assign tx_load = byte_done && ((st_r == ST_CMD && rx_byte[7:4] == OP_READ)
                     || (st_r == ST_DATA && is_read_r));
    assign rd_addr = (st_r == ST_CMD) ? rx_byte[3:0] : ptr_next;

    always_comb begin
        rd_val = 8'h00;
        if (rd_addr <= ADDR_POT1) begin
            rd_val = vol_r ? {1'b0, wiper_r[rd_addr[0]]}
                           : nv_mem_r[rd_addr[2:0]];
        end else if (rd_addr <= ADDR_GP_LAST) begin
            rd_val = nv_mem_r[rd_addr[2:0]];
        end else if (rd_addr == ADDR_ACR) begin
            rd_val[ACR_VOL_BIT]  = vol_r;
            rd_val[ACR_SHUTDOWN_CONTROL_BIT] = shutdown_control_bit_r;
            rd_val[ACR_WIP_BIT]  = wip_r;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            tx_r       <= 8'h00;
            sdo_o      <= 1'b1;
            sdo_oe_n_o <= 1'b1;
        end else if (pin_r.cs_n || st_r != ST_DATA || !is_read_r) begin
            sdo_o      <= 1'b1;
            sdo_oe_n_o <= 1'b1;
            if (tx_load) begin
                tx_r <= rd_val;
            end
        end else if (tx_load) begin
            tx_r <= rd_val;
        end else if (sck_fall) begin
            sdo_o      <= tx_r[7];
            sdo_oe_n_o <= tx_r[7];
            tx_r       <= {tx_r[6:0], 1'b0};
        end
    end

    // ==========================================================
    // power-up recall and wipers
    logic recall_fire;

    assign recall_fire = !recall_done_r && (rcnt_r == 8'(NV_READY_CYC - 1));

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            rcnt_r        <= 8'h00;
            recall_done_r <= 1'b0;
        end else if (!recall_done_r) begin
            rcnt_r        <= rcnt_r + 8'h01;
            recall_done_r <= recall_fire;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            wiper_r[0] <= WIPER_PRESET;
            wiper_r[1] <= WIPER_PRESET;
        end else if (recall_fire) begin
            wiper_r[0] <= nv_mem_r[ADDR_POT0[2:0]][6:0];
            wiper_r[1] <= nv_mem_r[ADDR_POT1[2:0]][6:0];
        end else if (wr_ok && ptr_r <= ADDR_POT1) begin
            wiper_r[ptr_r[0]] <= rx_byte[6:0];
        end
    end

    // ==========================================================
    // access control register
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            vol_r      <= VOL_RST;
            shutdown_control_bit_r <= SHUTDOWN_CONTROL_RST;
        end else if (wr_ok && ptr_r == ADDR_ACR) begin
            vol_r      <= rx_byte[ACR_VOL_BIT];
            shutdown_control_bit_r <= rx_byte[ACR_SHUTDOWN_CONTROL_BIT];
        end
    end

    // ==========================================================
    // self-timed nv write
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            pend_r      <= 1'b0;
            pend_addr_r <= 3'h0;
            pend_data_r <= 8'h00;
            wip_r       <= 1'b0;
            wcnt_r      <= '0;
        end else begin
            if (wip_r) begin
                wcnt_r <= wcnt_r - WC_W'(1);
                if (wcnt_r == '0) begin
                    wip_r <= 1'b0;
                end
            end
            if (cs_rise) begin
                pend_r <= 1'b0;
                if (pend_r) begin
                    wip_r  <= 1'b1;
                    wcnt_r <= WC_W'(NV_WRITE_CYCLES - 1);
                end
            end else if (wr_ok && nv_target) begin
                pend_r      <= 1'b1;
                pend_addr_r <= ptr_r[2:0];
                pend_data_r <= rx_byte;
            end
        end
    end

    always_ff @(posedge mclk_i) begin
        if (wip_r && wcnt_r == '0) begin
            nv_mem_r[pend_addr_r] <= pend_data_r;
        end
    end

    // ==========================================================
    // analog side controls
    logic shutdown_control_act;

    assign shutdown_control_act = !(pin_r.shutdown_control_n && shutdown_control_bit_r);

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            wiper0_tap_o <= 7'h00;
            wiper1_tap_o <= 7'h00;
            shutdown_o   <= 1'b0;
            standby_o    <= 1'b1;
        end else begin
            wiper0_tap_o <= shutdown_control_act ? 7'h00 : wiper_r[0];
            wiper1_tap_o <= shutdown_control_act ? 7'h00 : wiper_r[1];
            shutdown_o   <= shutdown_control_act;
            standby_o    <= pin_r.cs_n && !wip_r;
        end
    end

    // ==========================================================
    // assertions
    property p_preset;
        $past(!rst_n_i) |-> wiper_r[0] == 7'h40 && wiper_r[1] == 7'h40;
    endproperty
    a_preset: assert property (p_preset) else $error("wiper not preset");

    property p_recall;
        $rose(recall_done_r) |-> wiper_r[1] == nv_mem_r[1][6:0];
    endproperty
    a_recall: assert property (p_recall) else $error("recall missed");

    property p_shutdown;
        shutdown_control_act |=> wiper0_tap_o == 7'h00 && shutdown_o;
    endproperty
    a_shutdown: assert property (p_shutdown) else $error("shutdown tap wrong");

    property p_restore;
        !shutdown_control_act ##1 !shutdown_control_act |-> wiper1_tap_o == $past(wiper_r[1]);
    endproperty
    a_restore: assert property (p_restore) else $error("tap not restored");

    property p_reject;
        wr_fire && wip_r |=> $stable(vol_r) && $stable(shutdown_control_bit_r) && $stable(wiper_r[0]);
    endproperty
    a_reject: assert property (p_reject) else $error("write during busy");

    property p_vol_write;
        wr_ok && !vol_r && ptr_r == 4'h0 |=> wiper_r[0] == $past(rx_byte[6:0]) && pend_r;
    endproperty
    a_vol_write: assert property (p_vol_write) else $error("dual write failed");

    property p_nv_start;
        cs_rise && pend_r |=> wip_r ##1 wip_r;
    endproperty
    a_nv_start: assert property (p_nv_start) else $error("nv write not started");

    property p_wrap;
        byte_done && st_r == ST_DATA && ptr_r == 4'h6 |=> ptr_r == 4'h0;
    endproperty
    a_wrap: assert property (p_wrap) else $error("pointer wrap wrong");

    property p_acr_low;
        tx_load && rd_addr == 4'h8 |=> tx_r[4:0] == 5'h00;
    endproperty
    a_acr_low: assert property (p_acr_low) else $error("control low bits set");

    property p_release;
        pin_r.cs_n || st_r == ST_IGNORE |=> sdo_oe_n_o;
    endproperty
    a_release: assert property (p_release) else $error("output not released");

    property p_read_keeps;
        tx_load && recall_done_r |=> $stable(wiper_r[0]) && $stable(wiper_r[1]);
    endproperty
    a_read_keeps: assert property (p_read_keeps) else $error("read moved wiper");

    property p_standby;
        pin_r.cs_n && !wip_r |=> standby_o;
    endproperty
    a_standby: assert property (p_standby) else $error("standby not entered");

    property p_bad_id;
        byte_done && st_r == ST_ID && rx_byte != ID_BYTE |=> st_r == ST_IGNORE;
    endproperty
    a_bad_id: assert property (p_bad_id) else $error("bad id accepted");

    property p_ignore_hold;
        st_r == ST_IGNORE && recall_done_r |=> $stable(wiper_r[0]) && !pend_r;
    endproperty
    a_ignore_hold: assert property (p_ignore_hold) else $error("ignored frame wrote");

    property p_acr_only;
        wr_ok && ptr_r == ADDR_ACR |=> !wip_r && !pend_r;
    endproperty
    a_acr_only: assert property (p_acr_only) else $error("control began nv");

    property p_read_inc;
        byte_done && st_r == ST_DATA && is_read_r && ptr_r == 4'h2 |=> ptr_r == 4'h3;
    endproperty
    a_read_inc: assert property (p_read_inc) else $error("read pointer stuck");

    property p_shutdown_control_serial;
        shutdown_control_act && sck_rise && st_r == ST_ID && bitcnt_r == 3'h0 |=> bitcnt_r == 3'h1;
    endproperty
    a_shutdown_control_serial: assert property (p_shutdown_control_serial) else $error("shutdown stall");

    c_write: cover property (wr_ok && nv_target);
    c_read: cover property (tx_load && st_r == ST_DATA);
    c_bad_id: cover property (st_r == ST_ID ##1 st_r == ST_IGNORE);
    c_nv_done: cover property (wip_r ##1 !wip_r);
    c_wrap: cover property (byte_done && st_r == ST_DATA && ptr_r == 4'h6);

endmodule // dps_top

// ===== hw/dps_pkg.sv
// constants, types and carriers of the dual pot serial register slave
package dps_pkg;

    // ==========================================================
    // timing
    localparam int CLK_KHZ      = 25000;
    localparam int NV_WRITE_MS  = 20;
    localparam int NV_WRITE_CYC = NV_WRITE_MS * CLK_KHZ;
    localparam int NV_READY_US  = 1;
    localparam int NV_READY_CYC = (NV_READY_US * CLK_KHZ + 999) / 1000;

    // ==========================================================
    // protocol codes
    localparam logic [7:0] ID_BYTE  = 8'h90; // device code value is arbitrary
    localparam logic [3:0] OP_READ  = 4'hb;
    localparam logic [3:0] OP_WRITE = 4'hc;

    // ==========================================================
    // register map
    localparam logic [3:0] ADDR_POT0     = 4'h0;
    localparam logic [3:0] ADDR_POT1     = 4'h1;
    localparam logic [3:0] ADDR_GP_FIRST = 4'h2;
    localparam logic [3:0] ADDR_GP_LAST  = 4'h6;
    localparam logic [3:0] ADDR_RSVD     = 4'h7;
    localparam logic [3:0] ADDR_ACR      = 4'h8;
    localparam int         NV_CNT        = 7;

    // ==========================================================
    // access control fields and reset values
    localparam int         ACR_VOL_BIT   = 7;
    localparam int         ACR_SHUTDOWN_CONTROL_BIT  = 6;
    localparam int         ACR_WIP_BIT   = 5;
    localparam logic       VOL_RST       = 1'b0;
    localparam logic       SHUTDOWN_CONTROL_RST      = 1'b1;
    localparam logic [6:0] WIPER_PRESET  = 7'h40;
    localparam logic [7:0] NV_ERASED     = 8'h40;

    // ==========================================================
    // types
    typedef enum logic [2:0] {
        ST_IDLE   = 3'h0,
        ST_ID     = 3'h1,
        ST_CMD    = 3'h3,
        ST_DATA   = 3'h2,
        ST_IGNORE = 3'h6
    } dps_state_t;

    typedef struct packed {
        logic cs_n;
        logic sck;
        logic sdi;
        logic shutdown_control_n;
    } dps_pins_t;

    localparam dps_pins_t PIN_IDLE = '{cs_n: 1'b1, sck: 1'b0, sdi: 1'b0, shutdown_control_n: 1'b1};

endpackage

// ===== dv/dps_host.sv
// serial host model driving chip select, clock, data and shutdown pins
`timescale 1ns/1ns
module dps_host
    import dps_pkg::*;
(
    input  wire logic       mclk_i,
    input  wire logic       sdo_line_i,
    output dps_pins_t       pins_o,
    output logic            rx_stb_o,
    output logic [7:0]      rx_byte_o
);
    // ==========================================================
    // state
    logic [7:0] txq [$];

    initial begin
        pins_o    = PIN_IDLE;
        rx_stb_o  = 1'b0;
        rx_byte_o = 8'hff;
    end

    // ==========================================================
    // tasks
    task automatic push(input logic [7:0] b);
        txq.push_back(b);
    endtask

    task automatic set_shutdown_control(input logic v);
        @(negedge mclk_i);
        pins_o.shutdown_control_n = v;
    endtask

    // one frame: cs low, all queued bytes msb first, cs high
    task automatic xfer();
        logic [7:0] t;
        logic [7:0] r;
        @(negedge mclk_i);
        pins_o.cs_n = 1'b0;
        repeat (4) @(negedge mclk_i);
        while (txq.size() > 0) begin
            t = txq.pop_front();
            for (int i = 7; i >= 0; i--) begin
                pins_o.sdi = t[i];
                repeat (4) @(negedge mclk_i);
                pins_o.sck = 1'b1;
                repeat (4) @(negedge mclk_i);
                r[i] = sdo_line_i;
                pins_o.sck = 1'b0;
            end
            rx_byte_o = r;
            rx_stb_o  = 1'b1;
            @(negedge mclk_i);
            rx_stb_o = 1'b0;
        end
        repeat (4) @(negedge mclk_i);
        pins_o.cs_n = 1'b1;
        pins_o.sdi  = ~pins_o.sdi;
        repeat (8) @(negedge mclk_i);
    endtask
endmodule // dps_host

// ===== dv/tb_top.sv
// self-checking bench of the dual pot serial register slave
`timescale 1ns/1ns
module tb_top
    import dps_pkg::*;
;
    // ==========================================================
    // signals
    localparam int NV_CYC = 1000;
    localparam int LIMIT  = 40000;
    logic       mclk;
    logic       rst_n;
    dps_pins_t  pins;
    logic       sdo, sdo_oe_n, shutdown, standby, rx_stb, exp_sd;
    logic [6:0] tap0, tap1;
    logic [7:0] rx_byte, w0, w1, g6, iv;
    logic [7:0] exq [$];
    int         seed = 24;
    int         mismatches = 0;
    int         checked = 0;
    int         cyc = 0;
    wire        sdo_line = sdo_oe_n ? 1'b1 : sdo;

    // ==========================================================
    // instances
    dps_top #(.NV_WRITE_CYCLES(NV_CYC)) i_dps_top (
        .mclk_i(mclk), .rst_n_i(rst_n), .sck_i(pins.sck), .cs_n_i(pins.cs_n),
        .sdi_i(pins.sdi), .shutdown_control_n_i(pins.shutdown_control_n), .sdo_o(sdo), .sdo_oe_n_o(sdo_oe_n),
        .wiper0_tap_o(tap0), .wiper1_tap_o(tap1), .shutdown_o(shutdown),
        .standby_o(standby)
    );
    dps_host i_dps_host (
        .mclk_i(mclk), .sdo_line_i(sdo_line), .pins_o(pins), .rx_stb_o(rx_stb),
        .rx_byte_o(rx_byte)
    );

    // ==========================================================
    // helpers
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic report_and_stop();
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    function automatic logic [7:0] rnd();
        return 8'($random(seed));
    endfunction

    task automatic tick(input int n);
        repeat (n) @(negedge mclk);
    endtask

    task automatic b(input logic [7:0] tx, input logic [7:0] ex);
        i_dps_host.push(tx);
        exq.push_back(ex);
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        b(ID_BYTE, 8'hff);
        b({OP_WRITE, a}, 8'hff);
        b(d, 8'hff);
        i_dps_host.xfer();
    endtask

    task automatic rd(input logic [3:0] a, input logic [7:0] ex);
        b(ID_BYTE, 8'hff);
        b({OP_READ, a}, 8'hff);
        b(rnd(), ex);
        i_dps_host.xfer();
    endtask

    // ==========================================================
    // clock, timeout, monitor
    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end

    always @(posedge mclk) begin
        cyc = cyc + 1;
        if (cyc == LIMIT) begin
            mismatches++;
            report_and_stop();
        end
    end

    always @(posedge rx_stb) begin
        check("sdo byte", rx_byte, exq.pop_front());
    end

    // ==========================================================
    // scenarios
    initial begin
        rst_n = 1'b0;
        tick(6);
        rst_n = 1'b1;
        tick(30);
        check("tap0", {1'b0, tap0}, 8'h40);
        check("tap1", {1'b0, tap1}, 8'h40);
        check("idle", {5'h0, shutdown, standby, sdo_oe_n}, 8'h03);
        // bad id or opcode
        b(8'h91, 8'hff); b({OP_WRITE, ADDR_POT0}, 8'hff); b(8'h11, 8'hff);
        i_dps_host.xfer();
        b(8'hd0, 8'hff); b({OP_READ, ADDR_ACR}, 8'hff); b(rnd(), 8'hff);
        i_dps_host.xfer();
        b(ID_BYTE, 8'hff); b(8'ha0, 8'hff); b(8'h11, 8'hff);
        i_dps_host.xfer();
        check("tap0", {1'b0, tap0}, 8'h40);
        // volatile access, write wrap and read wrap
        wr(ADDR_ACR, 8'hc0);
        w0 = rnd() & 8'h7f;
        w1 = rnd() & 8'h7f;
        g6 = rnd();
        b(ID_BYTE, 8'hff); b({OP_WRITE, ADDR_GP_LAST}, 8'hff);
        b(g6, 8'hff); b(w0, 8'hff); b(w1, 8'hff);
        i_dps_host.xfer();
        tick(NV_CYC + 20);
        check("tap0", {1'b0, tap0}, w0);
        check("tap1", {1'b0, tap1}, w1);
        b(ID_BYTE, 8'hff); b({OP_READ, ADDR_GP_FIRST}, 8'hff);
        b(rnd(), 8'h40); b(rnd(), 8'h40); b(rnd(), 8'h40); b(rnd(), 8'h40);
        b(rnd(), g6); b(rnd(), w0); b(rnd(), w1);
        i_dps_host.xfer();
        b(ID_BYTE, 8'hff); b({OP_READ, ADDR_ACR}, 8'hff); b(rnd(), 8'hc0); b(rnd(), w0);
        i_dps_host.xfer();
        rd(ADDR_RSVD, 8'h00);
        // shutdown pin and bit combinations
        for (int k = 0; k < 4; k++) begin
            i_dps_host.set_shutdown_control(k[1]);
            wr(ADDR_ACR, {1'b1, k[0], 6'h3f});
            exp_sd = !(k[1] && k[0]);
            check("shutdown", {7'h0, shutdown}, {7'h0, exp_sd});
            check("tap0", {1'b0, tap0}, exp_sd ? 8'h00 : w0);
            check("standby", {7'h0, standby}, 8'h01);
            rd(ADDR_POT1, w1);
            rd(ADDR_ACR, {1'b1, k[0], 6'h00});
        end
        // non-volatile write, pending refusal, read-back of the stored value
        iv = rnd() & 8'h7f;
        wr(ADDR_ACR, 8'h40);
        wr(ADDR_POT0, iv);
        check("standby", {7'h0, standby}, 8'h00);
        check("tap0", {1'b0, tap0}, iv);
        rd(ADDR_ACR, 8'h60);
        wr(ADDR_GP_FIRST, 8'h11);
        wr(ADDR_ACR, 8'hc0);
        tick(NV_CYC);
        rd(ADDR_ACR, 8'h40);
        rd(ADDR_GP_FIRST, 8'h40);
        rd(ADDR_POT0, iv);
        w0 = iv ^ 8'h2a;
        wr(ADDR_ACR, 8'hc0);
        wr(ADDR_POT0, w0);
        wr(ADDR_ACR, 8'h40);
        rd(ADDR_POT0, iv);
        check("tap0", {1'b0, tap0}, w0);
        check("queue", 8'(exq.size()), 8'h00);
        report_and_stop();
    end
endmodule // tb_top
